// ==== ldc_pkg.sv ====
package ldc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADR_P0SEL = 9'h0B6;
    localparam logic [ADDR_W-1:0] ADR_P1SEL = 9'h09C;
    localparam logic [ADDR_W-1:0] ADR_P2SEL = 9'h09D;
    localparam logic [ADDR_W-1:0] ADR_P3SEL = 9'h09E;
    localparam logic [ADDR_W-1:0] ADR_DIV_HI = 9'h0AA;
    localparam logic [ADDR_W-1:0] ADR_CTRL = 9'h0AB;
    localparam logic [ADDR_W-1:0] ADR_DIV_LO = 9'h0AC;
    localparam logic [ADDR_W-1:0] ADR_RAM_FIRST = 9'h1E0;
    localparam logic [ADDR_W-1:0] ADR_RAM_LAST = 9'h1F2;
    localparam int RAM_BYTES = 19;
    localparam int RAM_IDX_W = 5;
    localparam logic [RAM_IDX_W-1:0] RAM_LAST_IDX = 5'h12;
    localparam int CTL_SEL_BIT = 7;
    localparam int CTL_ON_BIT = 6;
    localparam int CTL_DUTY_BIT = 4;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam int P0_BITS = 3;
    localparam int NCOM = 8;
    localparam logic [NCOM-1:0] COM_MASK_SHORT = 8'h0F;
    localparam logic [NCOM-1:0] COM_MASK_LONG = 8'hFF;
    localparam logic [2:0] OSC_OPT_A = 3'h0;
    localparam logic [2:0] OSC_OPT_B = 3'h5;
    localparam logic [2:0] OSC_OPT_C = 3'h6;
    localparam int OPT_W = 5;
    localparam int OPT_IDLE_BIT = 3;
    localparam int OPT_KEEP_BIT = 4;
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] DIV_BYPASS = 9'h000;
    localparam int FRAME_W = 9;
    localparam int FRAME_MSB = FRAME_W - 1;
    localparam logic [FRAME_W-1:0] FRAME_LAST = 9'h1FF;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ldc_bus_req_t;

    typedef struct packed {
        logic [P0_BITS-1:0] p0_role;
        logic [7:0] p1_role;
        logic [7:0] p2_role;
        logic [7:0] p3_role;
        logic [P0_BITS-1:0] p0_lvl;
        logic [7:0] p1_lvl;
        logic [7:0] p2_lvl;
        logic [7:0] p3_lvl;
    } ldc_pins_t;

    typedef struct packed {
        logic lcd_active;
        logic led_active;
        logic frame_start;
    } ldc_status_t;

    function automatic logic [2:0] com_index(input logic [FRAME_W-1:0] cnt, input logic duty_long);
        return duty_long ? cnt[FRAME_MSB -: 3] : {1'b0, cnt[FRAME_MSB -: 2]};
    endfunction
endpackage

// ==== ldc_ram.sv ====
`timescale 1ns/1ps
module ldc_ram
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Software port
    input wire logic we,
    input wire logic re,
    input wire logic [RAM_IDX_W-1:0] idx,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic bypass_en,
    input wire logic [DATA_W-1:0] bypass_data,
    output logic [DATA_W-1:0] rdata,
    // Scan port
    input wire logic [2:0] com_sel,
    output logic [RAM_BYTES-1:0] col_bits,
    output logic [DATA_W-1:0] row_byte
);
    typedef struct packed {
        logic [RAM_BYTES-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0] rdata;
        logic [RAM_BYTES-1:0] col;
        logic [DATA_W-1:0] row;
    } ldc_ram_state_t;

    ldc_ram_state_t st_r;
    ldc_ram_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (we && idx <= RAM_LAST_IDX)
        begin
            st_nxt.mem[idx] = wdata;
        end
        // Register reads share this flop so read data always leave a register
        if (re)
        begin
            if (bypass_en)
                st_nxt.rdata = bypass_data;
            else if (idx <= RAM_LAST_IDX)
                st_nxt.rdata = st_r.mem[idx];
            else
                st_nxt.rdata = RESET_BYTE;
        end
        // LCD wants one bit of every byte; LED wants one whole byte
        for (int i = 0; i < RAM_BYTES; i++)
        begin
            st_nxt.col[i] = st_r.mem[i][com_sel];
        end
        st_nxt.row = st_r.mem[com_sel];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rdata = st_r.rdata;
    assign col_bits = st_r.col;
    assign row_byte = st_r.row;
endmodule

// ==== ldc_top.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module ldc_top
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire ldc_bus_req_t bus,
    output logic [DATA_W-1:0] rdata,
    // Option straps from pins
    input wire logic [2:0] oscillator_option_code,
    input wire logic led_idle_level_option,
    input wire logic lf_osc_keeps_running,
    // Power management, same clock
    input wire logic power_down,
    // Display pins and status
    output ldc_pins_t pins,
    output ldc_status_t status
);
    typedef struct packed {
        logic [P0_BITS-1:0] port0_pin_role_bits;
        logic [7:0] port1_pin_role_bits;
        logic [7:0] port2_pin_role_bits;
        logic [7:0] port3_pin_role_bits;
        logic divider_high_bit;
        logic [7:0] divider_low_byte;
        logic display_type_select;
        logic driver_enable;
        logic duty_long;
        logic [OPT_W-1:0] opt_s1;
        logic [OPT_W-1:0] opt_s2;
        logic [OPT_W-1:0] opt_s3;
        logic [OPT_W-1:0] opt_ok;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic [FRAME_W-1:0] frame_cnt;
        logic [2:0] com_idx_d;
        ldc_pins_t pins;
        ldc_status_t status;
    } ldc_top_state_t;

    ldc_top_state_t st_r;
    ldc_top_state_t st_nxt;

    logic [RAM_BYTES-1:0] col_bits;
    logic [DATA_W-1:0] row_byte;
    logic in_ram;
    logic [RAM_IDX_W-1:0] ram_idx;
    logic div_ok;
    logic [DIV_W-1:0] div_eff;
    logic lcd_run;
    logic led_run;
    logic idle_lvl;
    logic [NCOM-1:0] com_hot;

    function automatic logic [DATA_W-1:0] sfr_read(input ldc_top_state_t s, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        d = RESET_BYTE;
        unique case (a)
            ADR_P0SEL: d[P0_BITS-1:0] = s.port0_pin_role_bits;
            ADR_P1SEL: d = s.port1_pin_role_bits;
            ADR_P2SEL: d = s.port2_pin_role_bits;
            ADR_P3SEL: d = s.port3_pin_role_bits;
            ADR_DIV_HI: d[0] = s.divider_high_bit;
            ADR_DIV_LO: d = s.divider_low_byte;
            ADR_CTRL:
            begin
                d[CTL_SEL_BIT] = s.display_type_select;
                d[CTL_ON_BIT] = s.driver_enable;
                d[CTL_DUTY_BIT] = s.duty_long;
            end
            default: d = RESET_BYTE;
        endcase
        return d;
    endfunction

    function automatic logic [NCOM-1:0] com_onehot(input logic [2:0] idx, input logic duty_long);
        logic [NCOM-1:0] m;
        m = '0;
        m[idx] = 1'b1;
        return m & (duty_long ? COM_MASK_LONG : COM_MASK_SHORT);
    endfunction

    assign in_ram = bus.addr >= ADR_RAM_FIRST && bus.addr <= ADR_RAM_LAST;
    assign ram_idx = RAM_IDX_W'(bus.addr - ADR_RAM_FIRST);
    // Divider ignored under other oscillator options
    assign div_ok = st_r.opt_ok[2:0] == OSC_OPT_A || st_r.opt_ok[2:0] == OSC_OPT_B
                    || st_r.opt_ok[2:0] == OSC_OPT_C;
    assign div_eff = div_ok ? {st_r.divider_high_bit, st_r.divider_low_byte} : DIV_BYPASS;
    assign lcd_run = !st_r.display_type_select && st_r.driver_enable;
    // Low-speed oscillator alive in power-down keeps the scan going
    assign led_run = st_r.display_type_select && st_r.driver_enable
                     && (!power_down || st_r.opt_ok[OPT_KEEP_BIT]);
    assign idle_lvl = st_r.opt_ok[OPT_IDLE_BIT];
    assign com_hot = com_onehot(st_r.com_idx_d, st_r.duty_long);

    always_comb
    begin
        st_nxt = st_r;

        // Register writes
        if (bus.wr)
        begin
            unique case (bus.addr)
                ADR_P0SEL: st_nxt.port0_pin_role_bits = bus.wdata[P0_BITS-1:0];
                ADR_P1SEL: st_nxt.port1_pin_role_bits = bus.wdata;
                ADR_P2SEL: st_nxt.port2_pin_role_bits = bus.wdata;
                ADR_P3SEL: st_nxt.port3_pin_role_bits = bus.wdata;
                ADR_DIV_HI: st_nxt.divider_high_bit = bus.wdata[0];
                ADR_DIV_LO: st_nxt.divider_low_byte = bus.wdata;
                ADR_CTRL:
                begin
                    st_nxt.display_type_select = bus.wdata[CTL_SEL_BIT];
                    st_nxt.driver_enable = bus.wdata[CTL_ON_BIT];
                    st_nxt.duty_long = bus.wdata[CTL_DUTY_BIT];
                end
                default: ;
            endcase
        end

        // Straps are accepted only once two late stages agree
        st_nxt.opt_s1 = {lf_osc_keeps_running, led_idle_level_option, oscillator_option_code};
        st_nxt.opt_s2 = st_r.opt_s1;
        st_nxt.opt_s3 = st_r.opt_s2;
        if (st_r.opt_s2 == st_r.opt_s3)
            st_nxt.opt_ok = st_r.opt_s3;

        // Display clock as a tick; zero divides by one
        if (div_eff == DIV_BYPASS || st_r.div_cnt >= div_eff - 1'b1)
        begin
            st_nxt.div_cnt = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.div_cnt = st_r.div_cnt + 1'b1;
            st_nxt.tick = 1'b0;
        end

        // Frame of 512 display ticks, split into equal common slots
        st_nxt.status.frame_start = 1'b0;
        if (lcd_run || led_run)
        begin
            if (st_r.tick)
            begin
                st_nxt.frame_cnt = st_r.frame_cnt + 1'b1;
                st_nxt.status.frame_start = st_r.frame_cnt == FRAME_LAST;
            end
        end
        else
        begin
            st_nxt.frame_cnt = '0;
        end
        // RAM scan data arrive one cycle late; this keeps commons aligned
        st_nxt.com_idx_d = com_index(st_r.frame_cnt, st_r.duty_long);

        // Pin roles
        st_nxt.pins.p1_role = st_r.port1_pin_role_bits;
        st_nxt.pins.p3_role = st_r.port3_pin_role_bits;
        if (st_r.display_type_select)
        begin
            st_nxt.pins.p0_role = '0;
            st_nxt.pins.p2_role = '0;
        end
        else
        begin
            st_nxt.pins.p0_role = st_r.port0_pin_role_bits;
            st_nxt.pins.p2_role = st_r.port2_pin_role_bits;
        end

        // Pin levels
        st_nxt.pins.p0_lvl = '0;
        st_nxt.pins.p1_lvl = '0;
        st_nxt.pins.p2_lvl = '0;
        st_nxt.pins.p3_lvl = '0;
        if (st_r.display_type_select)
        begin
            if (led_run)
            begin
                // Lit level is the opposite of the idle level
                st_nxt.pins.p1_lvl = st_r.port1_pin_role_bits
                                     & (row_byte ^ {8{idle_lvl}});
                st_nxt.pins.p3_lvl = st_r.port3_pin_role_bits
                                     & (com_hot ^ {8{idle_lvl}});
            end
            else
            begin
                st_nxt.pins.p1_lvl = st_r.port1_pin_role_bits & {8{idle_lvl}};
                st_nxt.pins.p3_lvl = st_r.port3_pin_role_bits & {8{idle_lvl}};
            end
        end
        else if (lcd_run)
        begin
            // Bias voltages are applied outside; these are the logic phases
            st_nxt.pins.p1_lvl = st_r.port1_pin_role_bits & col_bits[7:0];
            st_nxt.pins.p2_lvl = st_r.port2_pin_role_bits & col_bits[15:8];
            st_nxt.pins.p0_lvl = st_r.port0_pin_role_bits & col_bits[18:16];
            st_nxt.pins.p3_lvl = st_r.port3_pin_role_bits & com_hot;
        end

        st_nxt.status.lcd_active = lcd_run;
        st_nxt.status.led_active = led_run;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    ldc_ram u_ram (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(bus.wr && in_ram),
        .re(bus.rd),
        .idx(ram_idx),
        .wdata(bus.wdata),
        .bypass_en(!in_ram),
        .bypass_data(sfr_read(st_r, bus.addr)),
        .rdata(rdata),
        .com_sel(com_index(st_r.frame_cnt, st_r.duty_long)),
        .col_bits(col_bits),
        .row_byte(row_byte)
    );

    assign pins = st_r.pins;
    assign status = st_r.status;

    // Checking helpers
    logic [DIV_W:0] gap_r;
    logic div_same_r;
    logic [DIV_W-1:0] div_prev_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            gap_r <= '0;
            div_same_r <= 1'b0;
            div_prev_r <= '0;
        end
        else
        begin
            div_prev_r <= div_eff;
            gap_r <= st_r.tick ? (DIV_W+1)'(1) : gap_r + 1'b1;
            if (div_eff != div_prev_r)
                div_same_r <= 1'b0;
            else if (st_r.tick)
                div_same_r <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_p1_write;
        bus.wr && bus.addr == ADR_P1SEL;
    endsequence

    sequence s_p3_write;
        bus.wr && bus.addr == ADR_P3SEL;
    endsequence

    AST_P1_ROLE: assert property (s_p1_write ##1 !bus.wr [*2] |-> pins.p1_role == $past(bus.wdata, 2))
        else $error("port-1 role does not follow its select register");
    AST_P3_ROLE: assert property (s_p3_write ##1 !bus.wr [*2] |-> pins.p3_role == $past(bus.wdata, 2))
        else $error("port-3 role does not follow its select register");
    AST_LED_IGNORES_P0_P2: assert property (st_r.display_type_select |=> pins.p2_role == '0 && pins.p0_role == '0)
        else $error("port-0 or port-2 role active in LED mode");
    AST_NEVER_BOTH: assert property (!(status.lcd_active && status.led_active))
        else $error("LCD and LED drivers active together");
    AST_LED_IDLE_LEVEL: assert property (st_r.display_type_select && !led_run
        |=> pins.p3_lvl == (pins.p3_role & {8{$past(idle_lvl)}}))
        else $error("LED commons not at idle level while off");
    AST_PD_STOPS_LED: assert property (power_down && !st_r.opt_ok[OPT_KEEP_BIT]
        |=> !status.led_active)
        else $error("LED still scanning in power-down without low-speed oscillator");
    AST_LED_ENABLE: assert property (st_r.display_type_select && st_r.driver_enable && !power_down
        |=> status.led_active)
        else $error("LED driver enabled but not running");
    AST_DIV_SPACING: assert property (st_r.tick && div_same_r
        |-> gap_r == (div_prev_r == DIV_BYPASS ? (DIV_W+1)'(1) : {1'b0, div_prev_r}))
        else $error("display clock tick spacing differs from divider value");
    AST_DIV_BLOCKED: assert property (!div_ok [*2] |-> st_r.tick)
        else $error("divider active under an unsupported oscillator option");
    AST_FRAME_WRAP: assert property ((lcd_run || led_run) && st_r.tick && st_r.frame_cnt == FRAME_LAST
        |=> st_r.frame_cnt == '0 && status.frame_start)
        else $error("frame does not close after 512 display ticks");
    AST_ONE_COMMON: assert property (status.lcd_active |-> $countones(pins.p3_lvl) <= 1)
        else $error("more than one LCD common active");
    AST_RESET_CLEARS: assert property (@(posedge mclk) disable iff (1'b0) !rst_n
        |=> st_r.port1_pin_role_bits == '0 && st_r.driver_enable == 1'b0
            && st_r.display_type_select == 1'b0 && st_r.divider_low_byte == '0)
        else $error("reset leaves a control field set");

    // Pins left as general I/O must never carry a display level
    AST_IO_P1_QUIET: assert property ((pins.p1_lvl & ~pins.p1_role) == '0)
        else $error("port-1 I/O pin carries a display level");
    AST_IO_P2_QUIET: assert property ((pins.p2_lvl & ~pins.p2_role) == '0)
        else $error("port-2 I/O pin carries a display level");
    AST_IO_P3_QUIET: assert property ((pins.p3_lvl & ~pins.p3_role) == '0)
        else $error("port-3 I/O pin carries a display level");
    AST_IO_P0_QUIET: assert property ((pins.p0_lvl & ~pins.p0_role) == '0)
        else $error("port-0 I/O pin carries a display level");
    AST_LED_P0_P2_DARK: assert property (status.led_active |-> pins.p2_lvl == '0 && pins.p0_lvl == '0)
        else $error("port-0 or port-2 driven while LED scans");
    AST_LCD_SHORT_COMMONS: assert property (status.lcd_active && !$past(st_r.duty_long)
        |-> (pins.p3_lvl & ~COM_MASK_SHORT) == '0)
        else $error("upper LCD common active in quarter duty");
    AST_LED_SHORT_COMMONS: assert property (status.led_active && !$past(st_r.duty_long) && !$past(idle_lvl)
        |-> (pins.p3_lvl & ~COM_MASK_SHORT) == '0)
        else $error("upper LED common active in quarter duty");
    AST_LED_ONE_COMMON: assert property (status.led_active && !$past(idle_lvl) |-> $countones(pins.p3_lvl) <= 1)
        else $error("more than one LED common active");
    AST_LCD_OFF_DARK: assert property (!st_r.display_type_select && !st_r.driver_enable
        |=> pins.p1_lvl == '0 && pins.p3_lvl == '0)
        else $error("LCD pins toggle while LCD driver is off");
    AST_LED_OFF_SEGMENTS: assert property (st_r.display_type_select && !led_run
        |=> pins.p1_lvl == (pins.p1_role & {8{$past(idle_lvl)}}))
        else $error("LED segments not at idle level while off");
    AST_LCD_OFF_IN_LED: assert property (st_r.display_type_select |=> !status.lcd_active)
        else $error("LCD running while LED type selected");
    AST_LED_OFF_IN_LCD: assert property (!st_r.display_type_select |=> !status.led_active)
        else $error("LED running while LCD type selected");
    AST_DRIVER_OFF: assert property (!st_r.driver_enable |=> !status.led_active && !status.lcd_active)
        else $error("display driver running while disabled");
    AST_PD_KEEPS_LED: assert property (st_r.display_type_select && st_r.driver_enable && power_down
        && st_r.opt_ok[OPT_KEEP_BIT] |=> status.led_active)
        else $error("LED stopped in power-down with low-speed oscillator running");
    AST_FRAME_PULSE: assert property (status.frame_start |=> !status.frame_start)
        else $error("frame start pulse longer than one cycle");
    AST_DIV_HI_READ: assert property (bus.rd && bus.addr == ADR_DIV_HI |=> rdata[DATA_W-1:1] == '0)
        else $error("divider high register reads reserved bits set");
    AST_P0_READ: assert property (bus.rd && bus.addr == ADR_P0SEL |=> rdata[DATA_W-1:P0_BITS] == '0)
        else $error("port-0 select register reads reserved bits set");
    AST_CTRL_READ: assert property (bus.rd && bus.addr == ADR_CTRL |=> rdata[CTL_DUTY_BIT-1:0] == '0)
        else $error("control register reads reserved low bits set");
endmodule

// ==== ldc_panel.sv ====
`timescale 1ns/1ps
module ldc_panel
    import ldc_pkg::*;
(
    // Pins from the device
    input wire ldc_pins_t pins,
    input wire logic inv,
    // What the glass sees
    output logic [7:0] com_hot,
    output logic [7:0] seg_lo,
    output logic [7:0] seg_mid,
    output logic [2:0] seg_hi
);
    // Pins left as general I/O never reach the glass
    assign com_hot = (pins.p3_lvl ^ {8{inv}}) & pins.p3_role;
    assign seg_lo = (pins.p1_lvl ^ {8{inv}}) & pins.p1_role;
    assign seg_mid = (pins.p2_lvl ^ {8{inv}}) & pins.p2_role;
    assign seg_hi = (pins.p0_lvl ^ {3{inv}}) & pins.p0_role;
endmodule

// ==== ldc_top_tb.sv ====
`timescale 1ns/1ps
module ldc_top_tb
    import ldc_pkg::*;
;
    logic mclk;
    logic rst_n;
    ldc_bus_req_t bus;
    logic [DATA_W-1:0] rdata;
    logic [2:0] osc_code;
    logic idle_lvl;
    logic keep_run;
    logic pd;
    ldc_pins_t pins;
    ldc_status_t status;
    logic inv;
    logic [7:0] com_hot;
    logic [7:0] seg_lo;
    logic [7:0] seg_mid;
    logic [2:0] seg_hi;
    logic [7:0] ram [RAM_BYTES];
    logic [8:0] regs [7];
    logic [7:0] msk [7];
    logic [2:0] codes [5];
    int divs [5];
    int n_fail = 0;
    int check_count = 0;

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    ldc_top DUT (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .oscillator_option_code(osc_code),
        .led_idle_level_option(idle_lvl), .lf_osc_keeps_running(keep_run), .power_down(pd),
        .pins(pins), .status(status));
    ldc_panel PANEL (.pins(pins), .inv(inv), .com_hot(com_hot), .seg_lo(seg_lo), .seg_mid(seg_mid),
        .seg_hi(seg_hi));

    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        chk_byte({7'h0, exp}, {7'h0, got});
    endtask

    task automatic chk_cnt(input int exp, input int got);
        check_count++;
        if (got != exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        chk_byte(exp, rdata);
    endtask

    task automatic wait_frame(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge mclk);
            #1 cyc++;
            if (cyc > 3000)
            begin
                n_fail++;
                report_and_stop();
            end
        end while (status.frame_start !== 1'b1);
    endtask

    // Samples mid-slot so the RAM pipeline delay cannot matter
    task automatic scan(input logic led, input logic long_d);
        int c;
        int n;
        int slot;
        int j;
        logic [7:0] e1;
        logic [7:0] e2;
        logic [2:0] e0;
        n = long_d ? 8 : 4;
        slot = long_d ? 64 : 128;
        wait_frame(c);
        tick(slot / 2);
        for (c = 0; c < n; c++)
        begin
            #1;
            e1 = ram[c];
            for (j = 0; j < 8; j++)
            begin
                if (!led)
                    e1[j] = ram[j][c];
                e2[j] = led ? 1'b0 : ram[8 + j][c];
                if (j < 3)
                    e0[j] = led ? 1'b0 : ram[16 + j][c];
            end
            chk_byte(8'h01 << c, com_hot);
            chk_byte(e1, seg_lo);
            chk_byte(e2, seg_mid);
            chk_byte({5'h0, e0}, {5'h0, seg_hi});
            tick(slot);
        end
    endtask

    initial
    begin
        int i;
        int c;
        rst_n = 1'b0;
        bus = '0;
        osc_code = 3'h0;
        idle_lvl = 1'b0;
        keep_run = 1'b0;
        pd = 1'b0;
        inv = 1'b0;
        regs = '{ADR_P0SEL, ADR_P1SEL, ADR_P2SEL, ADR_P3SEL, ADR_DIV_HI, ADR_CTRL, ADR_DIV_LO};
        msk = '{8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h50, 8'hFF};
        codes = '{3'h0, 3'h5, 3'h6, 3'h1, 3'h7};
        divs = '{1536, 1536, 1536, 512, 512};
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        for (i = 0; i < 7; i++)
            rchk(regs[i], 8'h00);
        for (i = 0; i < 7; i++)
            wr(regs[i], (i == 5) ? 8'h7F : 8'hFF);
        wr(9'h0A0, 8'hFF);
        for (i = 0; i < 7; i++)
            rchk(regs[i], msk[i]);
        rchk(9'h0A0, 8'h00);
        wr(ADR_P1SEL, 8'hA5);
        tick(1);
        #1;
        chk_byte(8'hA5, pins.p1_role);
        chk_byte(8'hFF, pins.p2_role);
        chk_byte(8'hFF, pins.p3_role);
        chk_byte(8'h07, {5'h0, pins.p0_role});
        chk_bit(1'b1, status.lcd_active);
        // Reset again in mid-run
        tick(1);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rchk(ADR_P1SEL, 8'h00);
        rchk(ADR_CTRL, 8'h00);
        for (i = 0; i < 4; i++)
            wr(regs[i], msk[i]);
        // Idle gap after the port-3 write lets its role check complete
        tick(2);
        for (i = 0; i < RAM_BYTES; i++)
        begin
            ram[i] = 8'h35 + 8'(i) * 8'h0D;
            wr(ADR_RAM_FIRST + 9'(i), ram[i]);
        end
        rchk(ADR_RAM_LAST, ram[18]);
        wr(ADR_CTRL, 8'h40);
        tick(1);
        #1;
        chk_bit(1'b1, status.lcd_active);
        chk_bit(1'b0, status.led_active);
        scan(1'b0, 1'b0);
        wr(ADR_CTRL, 8'h50);
        scan(1'b0, 1'b1);
        wr(ADR_CTRL, 8'h80);
        tick(1);
        #1;
        chk_bit(1'b0, status.lcd_active);
        chk_bit(1'b0, status.led_active);
        chk_byte(8'h00, pins.p2_role);
        chk_byte(8'h00, {5'h0, pins.p0_role});
        chk_byte(8'hFF, pins.p1_role);
        chk_byte(8'hFF, pins.p3_role);
        chk_byte(8'h00, pins.p1_lvl);
        wr(ADR_CTRL, 8'hC0);
        tick(1);
        #1;
        chk_bit(1'b1, status.led_active);
        scan(1'b1, 1'b0);
        wr(ADR_CTRL, 8'hD0);
        scan(1'b1, 1'b1);
        idle_lvl <= 1'b1;
        tick(8);
        // Panel flips with the idle level, so lit pins still read as ones
        inv <= 1'b1;
        scan(1'b1, 1'b1);
        pd <= 1'b1;
        tick(3);
        #1;
        chk_bit(1'b0, status.led_active);
        chk_byte(8'hFF, pins.p1_lvl);
        chk_byte(8'hFF, pins.p3_lvl);
        tick(1);
        keep_run <= 1'b1;
        tick(8);
        #1;
        chk_bit(1'b1, status.led_active);
        tick(1);
        pd <= 1'b0;
        keep_run <= 1'b0;
        idle_lvl <= 1'b0;
        wr(ADR_CTRL, 8'h40);
        wait_frame(c);
        wait_frame(c);
        chk_cnt(512, c);
        wr(ADR_DIV_LO, 8'h03);
        for (i = 0; i < 5; i++)
        begin
            tick(1);
            osc_code <= codes[i];
            tick(8);
            wait_frame(c);
            wait_frame(c);
            chk_cnt(divs[i], c);
        end
        report_and_stop();
    end
endmodule
